/* dv/pin_world.sv */
`timescale 1ns/100ps
// Pads and the devices hung on them: a pad the block drives follows the
// block, any other pad shows what the outside device puts on it
module pin_world (
    input  wire logic [15:0] pad_out,
    input  wire logic [15:0] pad_oe,
    input  wire logic [15:0] ext_lvl,
    output logic      [15:0] pad_in
);
    // Wire level; a released pad never keeps the last driven value
    always_comb begin
        pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
    end
endmodule

/* dv/tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_top;
    logic        core_clk = 1'b0;           // 40 MHz system clock
    logic        rst      = 1'b1;           // Synchronous reset
    logic        psel     = 1'b0;           // APB select
    logic        penable  = 1'b0;           // APB access phase
    logic        pwrite   = 1'b0;           // APB direction
    logic [7:0]  paddr    = 8'h00;          // APB address
    logic [31:0] pwdata   = 32'h0000_0000;  // APB write data
    logic        pready, pslverr, err;      // Answer and captured error
    logic [31:0] prdata, rd;                // Read data and captured copy
    logic [15:0] pad_in, pad_out, pad_oe, analog_sel, periph_in;
    logic [15:0] ext_lvl = 16'h0000;        // Outside level on undriven pads
    logic [15:0] pen = 16'h0000, pdrv = 16'h0000, pout = 16'h0000, ponly = 16'h0000;
    logic [63:0] remappable_input_only_pin = 64'h0000_0000_0000_0000; // Remappable pin levels
    logic        s2c, s2d, s2s;             // Serial-2 routed inputs
    logic [15:0] own, oe_x, out_x, lvl;     // Expected pad picture
    int          num_errors = 0;
    int          compares   = 0;

    // Clock
    always #12.5 core_clk = ~core_clk;

    pio_port i_pio_port (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .analog_sel(analog_sel), .periph_en(pen), .periph_drive(pdrv), .periph_out(pout),
        .periph_in_only(ponly), .periph_in(periph_in), .remappable_pin(remappable_input_only_pin),
        .serial2_clock_input(s2c), .serial2_data_input(s2d), .serial2_select_input(s2s));

    pin_world i_pin_world (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl),
        .pad_in(pad_in));

    // One APB transfer; an idle edge first keeps back-to-back calls legal
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 1'b0;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, ex, rd)
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Watchdog sized well above the two hundred or so cycles the tests need
    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            // Reset picture, first after power-up, then after a mid-run reset
            rdchk("dir", pio_pkg::OFS_DIR, {16'h0000, pio_pkg::DIR_RST});
            rdchk("sel1", pio_pkg::OFS_SEL1, 32'h0000_3F3F);
            rdchk("sel2", pio_pkg::OFS_SEL2, 32'h0000_003F);
            rdchk("ana", pio_pkg::OFS_ANA, 32'h0000_0000);
            `CHK("oe_rst", 16'h0000, pad_oe)
            apb(1'b1, pio_pkg::OFS_DIR, 32'h0000_0000);
            @(posedge core_clk);
            rst <= 1'b1;
            repeat (2) @(posedge core_clk);
            rst <= 1'b0;
            $display("Test reset %0d done", k);
        end
        // Output latch, pin write into the latch, pin read back
        apb(1'b1, pio_pkg::OFS_DIR, 32'hFFFF_0000);
        apb(1'b1, pio_pkg::OFS_LAT, 32'hFFFF_A5C3);
        rdchk("lat", pio_pkg::OFS_LAT, 32'h0000_A5C3);
        repeat (2) @(posedge core_clk);
        `CHK("oe_out", 16'hFFFF, pad_oe)
        `CHK("out", 16'hA5C3, pad_out)
        apb(1'b1, pio_pkg::OFS_PIN, 32'h0000_1234);
        rdchk("lat_pin", pio_pkg::OFS_LAT, 32'h0000_1234);
        repeat (4) @(posedge core_clk);
        rdchk("pin", pio_pkg::OFS_PIN, 32'h0000_1234);
        apb(1'b1, pio_pkg::OFS_ANA, 32'h0000_00FF);
        rdchk("ana_rd", pio_pkg::OFS_ANA, 32'h0000_00FF);
        `CHK("ana_out", 16'h00FF, analog_sel)
        $display("Test latch done");
        // Shared pins: peripheral ownership, port fallback, input-only, no loop-through
        // Pin 1: enabled idle peripheral, port drives a one, peripheral input reads zero (no loop-through)
        // Pin 3: peripheral owns an input pin; pin 7: input-only peripheral
        apb(1'b1, pio_pkg::OFS_DIR, 32'h0000_FF0D);
        apb(1'b1, pio_pkg::OFS_LAT, 32'h0000_00A2);
        pen <= 16'h00FF; pdrv <= 16'h00F9; pout <= 16'h0051; ponly <= 16'h0080;
        ext_lvl <= 16'hC3C3;
        repeat (6) @(posedge core_clk);
        own = pen & pdrv & ~ponly;
        oe_x = own | ~16'hFF0D;
        out_x = (own & pout) | (~own & 16'h00A2);
        lvl = (oe_x & out_x) | (~oe_x & ext_lvl);
        `CHK("oe_sh", oe_x, pad_oe)
        `CHK("out_sh", out_x & oe_x, pad_out & oe_x)
        `CHK("pin_in", lvl & ~(oe_x & ~own), periph_in)
        rdchk("pin_sh", pio_pkg::OFS_PIN, {16'h0000, lvl});
        $display("Test shared done");
        // Remap selectors across the field range, both pin polarities
        for (int n = 0; n < 64; n += 21) begin
            apb(1'b1, pio_pkg::OFS_SEL1, 32'h0000_0000 | (n << 8) | (63 - n));
            apb(1'b1, pio_pkg::OFS_SEL2, 32'h0000_0000 | ((n + 5) % 64));
            rdchk("sel1_rw", pio_pkg::OFS_SEL1, 32'h0000_0000 | (n << 8) | (63 - n));
            rdchk("sel2_rw", pio_pkg::OFS_SEL2, 32'h0000_0000 | ((n + 5) % 64));
            for (int p = 0; p < 2; p++) begin
                remappable_input_only_pin <= ((64'h1 << n) | (64'h1 << ((n + 5) % 64))) ^ {64{p[0]}};
                repeat (5) @(posedge core_clk);
                `CHK("s2_clk", ~p[0], s2c)
                `CHK("s2_dat", p[0], s2d)
                `CHK("s2_sel", ~p[0], s2s)
            end
        end
        apb(1'b1, pio_pkg::OFS_SEL1, 32'hFFFF_FFFF);
        apb(1'b1, pio_pkg::OFS_SEL2, 32'hFFFF_FFFF);
        rdchk("sel1_un", pio_pkg::OFS_SEL1, 32'h0000_3F3F);
        rdchk("sel2_un", pio_pkg::OFS_SEL2, 32'h0000_003F);
        $display("Test remap done");
        // Unmapped word: refused, read zero, nothing written
        apb(1'b1, 8'h18, 32'h0000_FFFF);
        `CHK("err_w", 1'b1, err)
        rdchk("unmap", 8'h18, 32'h0000_0000);
        `CHK("err_r", 1'b1, err)
        rdchk("dir_kept", pio_pkg::OFS_DIR, 32'h0000_FF0D);
        $display("Test unmapped done");
        finish_test();
    end
endmodule

/* rtl/pio_pkg.sv */
package pio_pkg;
    // Port width and remap pin count
    localparam int PORT_W = 16;                    // Bits in one parallel port
    localparam int SEL_W  = 6;                     // Width of a remap selector field
    localparam int RP_N   = 64;                    // Remappable pin numbers covered

    // Register byte offsets on the APB word map
    localparam logic [7:0] OFS_DIR  = 8'h00;       // Direction register
    localparam logic [7:0] OFS_LAT  = 8'h04;       // Output latch register
    localparam logic [7:0] OFS_PIN  = 8'h08;       // Pin level register
    localparam logic [7:0] OFS_ANA  = 8'h0C;       // Analog input select register
    localparam logic [7:0] OFS_SEL1 = 8'h10;       // Serial-2 clock/data input select
    localparam logic [7:0] OFS_SEL2 = 8'h14;       // Serial-2 select input select

    // Selector field positions
    localparam int CLK_SEL_LSB = 8;                // Clock selector, bits 13:8
    localparam int DAT_SEL_LSB = 0;                // Data selector, bits 5:0
    localparam int SS_SEL_LSB  = 0;                // Select selector, bits 5:0

    // Reset values
    localparam logic [15:0] DIR_RST  = 16'hFFFF;   // All pins inputs
    localparam logic [15:0] LAT_RST  = 16'h0000;   // Latch cleared
    localparam logic [15:0] ANA_RST  = 16'h0000;   // All pins digital
    localparam logic [5:0]  SEL_RST  = 6'h3F;      // Selectors reset to all ones
    localparam logic [15:0] VALID_MASK = 16'hFFFF; // Bits present on this variant
endpackage

/* rtl/pio_port.sv */
`timescale 1ns/100ps
module pio_port (
    input  wire logic        core_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    // Pads
    input  wire logic [15:0] pad_in,
    output logic      [15:0] pad_out,
    output logic      [15:0] pad_oe,
    output logic      [15:0] analog_sel,
    // Peripherals sharing the pins
    input  wire logic [15:0] periph_en,
    input  wire logic [15:0] periph_drive,
    input  wire logic [15:0] periph_out,
    input  wire logic [15:0] periph_in_only,
    output logic      [15:0] periph_in,
    // Remappable pin levels
    input  wire logic [63:0] remappable_pin,
    output logic             serial2_clock_input,
    output logic             serial2_data_input,
    output logic             serial2_select_input
);
    // Software registers
    logic [15:0] dir_r;      // Direction, one = input
    logic [15:0] dir_nxt;
    logic [15:0] lat_r;      // Output latch
    logic [15:0] lat_nxt;
    logic [15:0] ana_r;      // Analog input select
    logic [15:0] ana_nxt;
    logic [5:0]  clk_sel_r;  // Serial-2 clock input selector
    logic [5:0]  clk_sel_nxt;
    logic [5:0]  dat_sel_r;  // Serial-2 data input selector
    logic [5:0]  dat_sel_nxt;
    logic [5:0]  ss_sel_r;   // Serial-2 select input selector
    logic [5:0]  ss_sel_nxt;
    // Bus answer
    logic        pready_r;
    logic        pready_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    // Pad side
    logic [15:0] pad_out_r;
    logic [15:0] pad_out_nxt;
    logic [15:0] pad_oe_r;
    logic [15:0] pad_oe_nxt;
    logic [15:0] periph_in_r;
    logic [15:0] periph_in_nxt;
    logic        s2_clk_r;
    logic        s2_clk_nxt;
    logic        s2_dat_r;
    logic        s2_dat_nxt;
    logic        s2_ss_r;
    logic        s2_ss_nxt;
    // Synchronised inputs
    logic [15:0] pad_sync;
    logic [63:0] rp_sync;
    logic        setup_ph;   // APB setup phase seen
    logic        wr_go;      // Write takes effect this edge
    logic [15:0] wdat;       // Low half of write data

    // Pad levels cross into the clock domain first
    pio_sync_bank #(.W(16)) u_pad_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (pad_in),
        .sync_out (pad_sync)
    );

    // Remappable pin levels cross as well
    pio_sync_bank #(.W(64)) u_rp_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in (remappable_pin),
        .sync_out (rp_sync)
    );

    // Decode one selector into the chosen pin level
    function automatic logic pick_pin(input logic [63:0] pins, input logic [5:0] sel);
        pick_pin = pins[sel];
    endfunction

    // Force bits absent on this variant to zero
    function automatic logic [15:0] valid_only(input logic [15:0] v);
        valid_only = v & pio_pkg::VALID_MASK;
    endfunction

    // Setup cycle answers in the following access cycle, one wait-free cycle
    assign setup_ph = psel && !penable;
    assign wr_go    = psel && penable && pwrite && pready_r;
    assign wdat     = pwdata[15:0];

    // Register writes; reads hold the value
    always_comb begin
        dir_nxt     = dir_r;
        lat_nxt     = lat_r;
        ana_nxt     = ana_r;
        clk_sel_nxt = clk_sel_r;
        dat_sel_nxt = dat_sel_r;
        ss_sel_nxt  = ss_sel_r;
        if (wr_go) begin
            case (paddr)
                pio_pkg::OFS_DIR: begin
                    dir_nxt = wdat;
                end
                pio_pkg::OFS_LAT: begin
                    lat_nxt = wdat;
                end
                pio_pkg::OFS_PIN: begin
                    lat_nxt = wdat;
                end
                pio_pkg::OFS_ANA: begin
                    ana_nxt = wdat;
                end
                pio_pkg::OFS_SEL1: begin
                    clk_sel_nxt = wdat[pio_pkg::CLK_SEL_LSB +: 6];
                    dat_sel_nxt = wdat[pio_pkg::DAT_SEL_LSB +: 6];
                end
                pio_pkg::OFS_SEL2: begin
                    ss_sel_nxt = wdat[pio_pkg::SS_SEL_LSB +: 6];
                end
                default: begin
                    dir_nxt = dir_r;
                end
            endcase
        end
    end

    // Register file, inputs after reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dir_r     <= pio_pkg::DIR_RST;
            lat_r     <= pio_pkg::LAT_RST;
            ana_r     <= pio_pkg::ANA_RST;
            clk_sel_r <= pio_pkg::SEL_RST;
            dat_sel_r <= pio_pkg::SEL_RST;
            ss_sel_r  <= pio_pkg::SEL_RST;
        end else begin
            dir_r     <= dir_nxt;
            lat_r     <= lat_nxt;
            ana_r     <= ana_nxt;
            clk_sel_r <= clk_sel_nxt;
            dat_sel_r <= dat_sel_nxt;
            ss_sel_r  <= ss_sel_nxt;
        end
    end

    // Bus answer: ready raised in the access cycle, data registered with it
    always_comb begin
        pready_nxt  = setup_ph;
        prdata_nxt  = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        if (setup_ph) begin
            case (paddr)
                pio_pkg::OFS_DIR:  prdata_nxt = {16'h0000, valid_only(dir_r)};
                pio_pkg::OFS_LAT:  prdata_nxt = {16'h0000, valid_only(lat_r)};
                pio_pkg::OFS_PIN:  prdata_nxt = {16'h0000, valid_only(pad_sync)};
                pio_pkg::OFS_ANA:  prdata_nxt = {16'h0000, valid_only(ana_r)};
                pio_pkg::OFS_SEL1: prdata_nxt = {18'h0_0000, clk_sel_r, 2'b00, dat_sel_r};
                pio_pkg::OFS_SEL2: prdata_nxt = {26'h000_0000, ss_sel_r};
                default: begin
                    // Unmapped words answer with an error and zero data
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
    end

    // Register the bus answer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Output ownership and input gating per pin
    always_comb begin
        pad_out_nxt   = '0;
        pad_oe_nxt    = '0;
        periph_in_nxt = '0;
        for (int i = 0; i < 16; i++) begin
            if (pio_pkg::VALID_MASK[i]) begin
                // An input-only peripheral never competes for the driver
                if (periph_en[i] && periph_drive[i] && !periph_in_only[i]) begin
                    pad_out_nxt[i] = periph_out[i];
                    pad_oe_nxt[i]  = 1'b1;
                end else begin
                    pad_out_nxt[i] = lat_r[i];
                    pad_oe_nxt[i]  = !dir_r[i];
                end
                // Peripheral sees the pad only when the port is not driving it;
                // an input-only peripheral never owns the pad, so it is gated too
                periph_in_nxt[i] = pad_sync[i] && !(pad_oe_nxt[i] && !(periph_en[i]
                    && periph_drive[i] && !periph_in_only[i]));
            end
        end
    end

    // Remap selection into serial-2 inputs
    always_comb begin
        s2_clk_nxt = pick_pin(rp_sync, clk_sel_r);
        s2_dat_nxt = pick_pin(rp_sync, dat_sel_r);
        s2_ss_nxt  = pick_pin(rp_sync, ss_sel_r);
    end

    // Register pad and peripheral side outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pad_out_r   <= '0;
            pad_oe_r    <= '0;
            periph_in_r <= '0;
            s2_clk_r    <= 1'b0;
            s2_dat_r    <= 1'b0;
            s2_ss_r     <= 1'b0;
        end else begin
            pad_out_r   <= pad_out_nxt;
            pad_oe_r    <= pad_oe_nxt;
            periph_in_r <= periph_in_nxt;
            s2_clk_r    <= s2_clk_nxt;
            s2_dat_r    <= s2_dat_nxt;
            s2_ss_r     <= s2_ss_nxt;
        end
    end

    assign pready               = pready_r;
    assign prdata               = prdata_r;
    assign pslverr              = pslverr_r;
    assign pad_out              = pad_out_r;
    assign pad_oe               = pad_oe_r;
    assign analog_sel           = ana_r;
    assign periph_in            = periph_in_r;
    assign serial2_clock_input  = s2_clk_r;
    assign serial2_data_input   = s2_dat_r;
    assign serial2_select_input = s2_ss_r;

    // Direction one keeps the pad undriven unless a peripheral owns it
    dir_input_a: assert property (@(posedge core_clk) disable iff (rst)
        (dir_r[0] && !(periph_en[0] && periph_drive[0] && !periph_in_only[0]))
        |=> !pad_oe[0]) else $error("input pin driven");

    // Active peripheral takes the driver one cycle later
    periph_owns_a: assert property (@(posedge core_clk) disable iff (rst)
        (periph_en[3] && periph_drive[3] && !periph_in_only[3])
        |=> (pad_oe[3] && pad_out[3] == $past(periph_out[3])))
        else $error("peripheral not owning pin");

    // Idle peripheral leaves the latch on the pad
    port_drives_a: assert property (@(posedge core_clk) disable iff (rst)
        (periph_en[1] && !periph_drive[1] && !dir_r[1])
        |=> (pad_oe[1] && pad_out[1] == $past(lat_r[1])))
        else $error("port lost idle pin");

    // No loop-through when port drives
    no_loop_a: assert property (@(posedge core_clk) disable iff (rst)
        (!dir_r[2] && !periph_drive[2]) |=> !periph_in[2])
        else $error("loop through seen");

    // Pin level writes land in the latch
    pin_write_a: assert property (@(posedge core_clk) disable iff (rst)
        (wr_go && paddr == pio_pkg::OFS_PIN) |=> lat_r == $past(pwdata[15:0]))
        else $error("pin write missed latch");

    // Latch reads come back in the access cycle
    lat_read_a: assert property (@(posedge core_clk) disable iff (rst)
        (setup_ph && !pwrite && paddr == pio_pkg::OFS_LAT)
        |=> (pready && prdata[15:0] == $past(lat_r)))
        else $error("latch read wrong");

    // Unused selector bits read as zero
    sel_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        (setup_ph && paddr == pio_pkg::OFS_SEL1)
        |=> (prdata[15:14] == 2'b00 && prdata[7:6] == 2'b00
        && prdata[13:8] == $past(clk_sel_r))) else $error("selector read wrong");

    // Clock input follows the selected remappable pin
    clk_route_a: assert property (@(posedge core_clk) disable iff (rst)
        ##1 serial2_clock_input == $past(rp_sync[clk_sel_r]))
        else $error("clock remap wrong");

    // Select input follows its selector
    ss_route_a: assert property (@(posedge core_clk) disable iff (rst)
        ##1 serial2_select_input == $past(rp_sync[ss_sel_r]))
        else $error("select remap wrong");
endmodule

/* rtl/pio_sync_bank.sv */
`timescale 1ns/100ps
// Two-stage synchroniser bank for pin levels
module pio_sync_bank #(
    parameter int W = 16
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_r;   // First stage, read only by the second
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;   // Second stage
    logic [W-1:0] sync_nxt;

    // Next values of both stages
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    // Register both stages
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule
